// ===== hw/pin_mux_pkg.sv
// Purpose: Shared constants and types for the programmable pin block
// Assumes: 100 MHz system clock, 32-bit classic Wishbone register bus
// Notes: Ground speed is unsigned fixed point, metres per second Q8.8
`default_nettype none

package pin_mux_pkg;

  // ---------------------------------------------------------------
  // Function selection
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FN_NONE        = 2'h0,
    FN_POS_LOST    = 2'h1,
    FN_SPEED_PULSE = 2'h2,
    FN_LED         = 2'h3
  } pin_func_t;

  localparam int ARG_W = 12;

  typedef struct packed {
    logic [ARG_W-1:0] function_argument;
    pin_func_t func;
  } pin_cfg_t;

  // ---------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] PIN0_CFG_OFF = 8'h00;
  localparam logic [7:0] PIN1_CFG_OFF = 8'h04;
  localparam logic [7:0] EVENT_CFG_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;

  localparam int CFG_FUNC_LSB = 0;
  localparam int CFG_ARG_LSB = 16;
  localparam int EV_EDGE_BIT = 0;
  localparam int EV_ENABLE_BIT = 1;
  localparam int ST_PIN0_BIT = 0;
  localparam int ST_PIN1_BIT = 1;
  localparam int ST_POS_VALID_BIT = 2;
  localparam int ST_IN_RANGE_BIT = 3;
  localparam int ST_EVENT_BIT = 4;
  localparam int ST_LOST0_BIT = 5;
  localparam int ST_LOST1_BIT = 6;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam pin_cfg_t CFG_RESET = '{function_argument: 12'h000,
                                     func: FN_NONE};
  localparam logic EDGE_RESET = 1'b0;
  localparam logic EVENT_EN_RESET = 1'b0;
  localparam logic PIN_RESET = 1'b1;

  // ---------------------------------------------------------------
  // Argument codes
  // ---------------------------------------------------------------
  localparam logic [ARG_W-1:0] ARG_RSP_ON = 12'h001;
  localparam logic [ARG_W-1:0] ARG_LED_RED = 12'h001;
  localparam logic [ARG_W-1:0] ARG_LED_GREEN = 12'h002;
  localparam logic [ARG_W-1:0] TIMEOUT_MIN_S = 12'h001;
  localparam logic [ARG_W-1:0] TIMEOUT_MAX_S = 12'hE10;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ = 100_000_000;
  localparam longint SECOND_S = 1;
  localparam int unsigned TICKS_PER_SEC = 32'(SECOND_S * CLK_HZ);

  // ---------------------------------------------------------------
  // Speed pulse generator
  // ---------------------------------------------------------------
  localparam int SPEED_W = 16;
  localparam int SPEED_FRAC = 8;
  localparam int ACC_W = 40;
  localparam longint RSP_HZ_PER_MPS = 94;
  // Phase step per Q8.8 speed unit: 94 * 2^(ACC_W-FRAC) / CLK_HZ
  localparam logic [15:0] RSP_INC_K =
    16'((RSP_HZ_PER_MPS << (ACC_W - SPEED_FRAC)) / CLK_HZ);
  // Limits in tenths of km/h, turned into Q8.8 m/s
  localparam longint SPEED_MIN_KMH_X10 = 8;
  localparam longint SPEED_MAX_KMH_X10 = 3220;
  localparam logic [SPEED_W-1:0] SPEED_MIN_Q =
    16'(((SPEED_MIN_KMH_X10 << SPEED_FRAC) + 35) / 36);
  localparam logic [SPEED_W-1:0] SPEED_MAX_Q =
    16'((SPEED_MAX_KMH_X10 << SPEED_FRAC) / 36);

endpackage

`default_nettype wire

// ===== hw/pin_function_mux.sv
// Purpose: Programmable connector pins and event-marker edge selector
// Assumes: All inputs synchronous to clk_i; Wishbone classic slave
// Notes: Pin outputs and event pulse are registered
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`default_nettype none

module pin_function_mux #(
  parameter int unsigned TICKS_PER_SEC = pin_mux_pkg::TICKS_PER_SEC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pos_valid_i,
  input wire logic restart_i,
  input wire logic [15:0] ground_speed_i,
  input wire logic led_red_i,
  input wire logic led_green_i,
  input wire logic event_marker_i,
  output logic event_pulse_o,
  output logic prog_pin_zero_o,
  output logic prog_pin_one_o
);

  localparam int AW = pin_mux_pkg::ACC_W;
  localparam int W = pin_mux_pkg::ARG_W;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] cfg_word(input pin_mux_pkg::pin_cfg_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[pin_mux_pkg::CFG_FUNC_LSB +: 2] = c.func;
    w[pin_mux_pkg::CFG_ARG_LSB +: W] = c.function_argument;
    return w;
  endfunction

  function automatic pin_mux_pkg::pin_cfg_t word_cfg(input logic [31:0] w);
    pin_mux_pkg::pin_cfg_t c;
    c.func = pin_mux_pkg::pin_func_t'(w[pin_mux_pkg::CFG_FUNC_LSB +: 2]);
    c.function_argument = w[pin_mux_pkg::CFG_ARG_LSB +: W];
    return c;
  endfunction

  // ---------------------------------------------------------------
  // Register bus and configuration
  // ---------------------------------------------------------------
  pin_mux_pkg::pin_cfg_t cfg_q [2];
  pin_mux_pkg::pin_cfg_t cfg_d [2];
  logic edge_sel_q, edge_sel_d;
  logic event_en_q, event_en_d;
  logic event_flag_q, event_flag_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] assign_lost;
  logic [1:0] lost_q, lost_d;
  logic [1:0] pin_q, pin_d;
  logic in_range;
  logic ev_hit;

  logic req;
  logic wr;
  logic [31:0] ev_word;
  logic [31:0] st_word;
  logic [31:0] new_w;

  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~ack_q;
    wr = req & wb_we_i;
    cfg_d = cfg_q;
    edge_sel_d = edge_sel_q;
    event_en_d = event_en_q;
    assign_lost = 2'b00;
    ack_d = req;
    rdata_d = 32'h0000_0000;
    new_w = 32'h0000_0000;
    ev_word = 32'h0000_0000;
    ev_word[pin_mux_pkg::EV_EDGE_BIT] = edge_sel_q;
    ev_word[pin_mux_pkg::EV_ENABLE_BIT] = event_en_q;
    st_word = 32'h0000_0000;
    st_word[pin_mux_pkg::ST_PIN0_BIT] = pin_q[0];
    st_word[pin_mux_pkg::ST_PIN1_BIT] = pin_q[1];
    st_word[pin_mux_pkg::ST_POS_VALID_BIT] = pos_valid_i;
    st_word[pin_mux_pkg::ST_IN_RANGE_BIT] = in_range;
    st_word[pin_mux_pkg::ST_EVENT_BIT] = event_flag_q;
    st_word[pin_mux_pkg::ST_LOST0_BIT] = lost_q[0];
    st_word[pin_mux_pkg::ST_LOST1_BIT] = lost_q[1];
    // Hardware set wins over a software clear in the same cycle
    event_flag_d = ev_hit | event_flag_q;
    for (int i = 0; i < 2; i++) begin
      if (wr && wb_adr_i == (i == 0 ? pin_mux_pkg::PIN0_CFG_OFF
                                    : pin_mux_pkg::PIN1_CFG_OFF)) begin
        new_w = merge_bytes(cfg_word(cfg_q[i]), wb_dat_i, wb_sel_i);
        cfg_d[i] = word_cfg(new_w);
        assign_lost[i] = (cfg_d[i].func == pin_mux_pkg::FN_POS_LOST) &&
                         (cfg_q[i].func != pin_mux_pkg::FN_POS_LOST);
      end
    end
    if (wr && wb_adr_i == pin_mux_pkg::EVENT_CFG_OFF) begin
      if (wb_sel_i[0]) begin
        edge_sel_d = wb_dat_i[pin_mux_pkg::EV_EDGE_BIT];
        event_en_d = wb_dat_i[pin_mux_pkg::EV_ENABLE_BIT];
      end
    end
    if (wr && wb_adr_i == pin_mux_pkg::STATUS_OFF && wb_sel_i[0] &&
        wb_dat_i[pin_mux_pkg::ST_EVENT_BIT] && !ev_hit) begin
      event_flag_d = 1'b0;
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        pin_mux_pkg::PIN0_CFG_OFF: rdata_d = cfg_word(cfg_q[0]);
        pin_mux_pkg::PIN1_CFG_OFF: rdata_d = cfg_word(cfg_q[1]);
        pin_mux_pkg::EVENT_CFG_OFF: rdata_d = ev_word;
        pin_mux_pkg::STATUS_OFF: rdata_d = st_word;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q[0] <= pin_mux_pkg::CFG_RESET;
      cfg_q[1] <= pin_mux_pkg::CFG_RESET;
      edge_sel_q <= pin_mux_pkg::EDGE_RESET;
      event_en_q <= pin_mux_pkg::EVENT_EN_RESET;
      event_flag_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      cfg_q <= cfg_d;
      edge_sel_q <= edge_sel_d;
      event_en_q <= event_en_d;
      event_flag_q <= event_flag_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ---------------------------------------------------------------
  // Position monitor and speed accumulator
  // ---------------------------------------------------------------
  logic [31:0] presc_q, presc_d;
  logic [W-1:0] lost_secs_q, lost_secs_d;
  logic [AW-1:0] acc_q, acc_d;
  logic sec_tick;
  logic [W-1:0] limit;

  always_comb begin
    sec_tick = (presc_q == 32'(TICKS_PER_SEC - 1));
    // Second count restarts at each loss so a timeout is full seconds
    if (pos_valid_i || sec_tick) begin
      presc_d = 32'h0000_0000;
    end else begin
      presc_d = presc_q + 32'h0000_0001;
    end
    lost_secs_d = lost_secs_q;
    if (pos_valid_i) begin
      lost_secs_d = '0;
    end else if (sec_tick && lost_secs_q != {W{1'b1}}) begin
      lost_secs_d = lost_secs_q + 1'b1;
    end
    lost_d = lost_q;
    limit = '0;
    for (int i = 0; i < 2; i++) begin
      limit = cfg_q[i].function_argument;
      if (limit < pin_mux_pkg::TIMEOUT_MIN_S) begin
        limit = pin_mux_pkg::TIMEOUT_MIN_S;
      end
      if (!pos_valid_i) begin
        lost_d[i] = lost_q[i] | (lost_secs_q >= limit)
                    | assign_lost[i];
      end else begin
        lost_d[i] = 1'b0;
      end
      if (restart_i) begin
        lost_d[i] = 1'b1;
      end
    end
    in_range = (ground_speed_i >= pin_mux_pkg::SPEED_MIN_Q) &&
               (ground_speed_i <= pin_mux_pkg::SPEED_MAX_Q);
    if (in_range) begin
      acc_d = acc_q + AW'(ground_speed_i) *
                      AW'(pin_mux_pkg::RSP_INC_K);
    end else begin
      acc_d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_q <= 32'h0000_0000;
      lost_secs_q <= '0;
      lost_q <= 2'b00;
      acc_q <= '0;
    end else begin
      presc_q <= presc_d;
      lost_secs_q <= lost_secs_d;
      lost_q <= lost_d;
      acc_q <= acc_d;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers and event marker
  // ---------------------------------------------------------------
  logic ev_prev_q, ev_prev_d;
  logic ev_armed_q, ev_armed_d;
  logic ev_pulse_q, ev_pulse_d;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      case (cfg_q[i].func)
        pin_mux_pkg::FN_NONE: pin_d[i] = 1'b1;
        pin_mux_pkg::FN_POS_LOST: pin_d[i] = ~lost_d[i];
        pin_mux_pkg::FN_SPEED_PULSE: begin
          // MSB of the accumulator gives an even duty square wave
          if (cfg_q[i].function_argument == pin_mux_pkg::ARG_RSP_ON &&
              in_range) begin
            pin_d[i] = acc_q[AW-1];
          end else begin
            pin_d[i] = 1'b1;
          end
        end
        pin_mux_pkg::FN_LED: begin
          if (cfg_q[i].function_argument == pin_mux_pkg::ARG_LED_RED) begin
            pin_d[i] = led_red_i;
          end else if (cfg_q[i].function_argument ==
                       pin_mux_pkg::ARG_LED_GREEN) begin
            pin_d[i] = led_green_i;
          end else begin
            pin_d[i] = 1'b1;
          end
        end
        default: pin_d[i] = 1'b1;
      endcase
    end
    ev_prev_d = event_marker_i;
    ev_armed_d = 1'b1;
    ev_hit = ev_armed_q & event_en_q &
             (edge_sel_q ? (ev_prev_q & ~event_marker_i)
                         : (~ev_prev_q & event_marker_i));
    ev_pulse_d = ev_hit;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= {2{pin_mux_pkg::PIN_RESET}};
      ev_prev_q <= 1'b0;
      ev_armed_q <= 1'b0;
      ev_pulse_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      ev_prev_q <= ev_prev_d;
      ev_armed_q <= ev_armed_d;
      ev_pulse_q <= ev_pulse_d;
    end
  end

  assign prog_pin_zero_o = pin_q[0];
  assign prog_pin_one_o = pin_q[1];
  assign event_pulse_o = ev_pulse_q;

endmodule

`default_nettype wire

// ===== sim/pin_function_mux_chk.sv
// Purpose: Port-level assertions for the programmable pin block
// Assumes: Config words are written with all byte lanes enabled
// Notes: Pin config is tracked by snooping bus writes
`default_nettype none
module pin_function_mux_chk #(
  parameter int unsigned TICKS_PER_SEC = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pos_valid_i,
  input wire logic restart_i,
  input wire logic [15:0] ground_speed_i,
  input wire logic led_red_i,
  input wire logic led_green_i,
  input wire logic event_marker_i,
  input wire logic event_pulse_o,
  input wire logic prog_pin_zero_o,
  input wire logic prog_pin_one_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr, lost0, bad1;
  logic [13:0] cfg_q [2];
  logic [13:0] cfg_d [2];
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && &wb_sel_i;
  assign lost0 = cfg_q[0][1:0] == 2'h1;
  assign bad1 = cfg_q[1][1:0] == 2'h2 && (cfg_q[1][13:2] != 12'h001 ||
    ground_speed_i < pin_mux_pkg::SPEED_MIN_Q ||
    ground_speed_i > pin_mux_pkg::SPEED_MAX_Q);
  always_comb begin
    cfg_d = cfg_q;
    for (int i = 0; i < 2; i++) begin
      if (wr && wb_adr_i == 8'(4 * i)) begin
        cfg_d[i] = {wb_dat_i[27:16], wb_dat_i[1:0]};
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= '{default: 14'h0000};
    end else begin
      cfg_q <= cfg_d;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    s_req |=> s_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus request not acknowledged once");
  property p_reset;
    $fell(rst_i) |-> prog_pin_zero_o && prog_pin_one_o && !event_pulse_o;
  endproperty
  a_reset: assert property (p_reset)
    else $error("pins not high after reset");
  property p_none;
    (cfg_q[0][1:0] == 2'h0) [*2] |-> prog_pin_zero_o;
  endproperty
  a_none: assert property (p_none)
    else $error("unassigned pin not high");
  property p_assign;
    wr && wb_adr_i == 8'h00 && wb_dat_i[1:0] == 2'h1 && !lost0 &&
      !pos_valid_i |-> ##[1:2] !prog_pin_zero_o;
  endproperty
  a_assign: assert property (p_assign)
    else $error("lost pin not low on assignment");
  property p_restart;
    restart_i && lost0 |-> ##[1:2] !prog_pin_zero_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("lost pin not low after restart");
  property p_resume;
    (lost0 && pos_valid_i && !restart_i) [*3] |-> prog_pin_zero_o;
  endproperty
  a_resume: assert property (p_resume)
    else $error("lost pin not high with position");
  property p_led;
    (cfg_q[0] == 14'h0007) [*2] |-> prog_pin_zero_o == $past(led_red_i);
  endproperty
  a_led: assert property (p_led)
    else $error("pin does not follow red led");
  property p_spd;
    bad1 [*3] |-> prog_pin_one_o;
  endproperty
  a_spd: assert property (p_spd)
    else $error("pulse pin not steady high");
  property p_event;
    event_pulse_o |-> $past(event_marker_i) != $past(event_marker_i, 2) ||
      $past(event_marker_i, 2) != $past(event_marker_i, 3);
  endproperty
  a_event: assert property (p_event)
    else $error("event pulse without marker edge");
endmodule

bind pin_function_mux pin_function_mux_chk #(.TICKS_PER_SEC(TICKS_PER_SEC))
  i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pos_valid_i, .restart_i,
  .ground_speed_i, .led_red_i, .led_green_i, .event_marker_i,
  .event_pulse_o, .prog_pin_zero_o, .prog_pin_one_o);
`default_nettype wire

// ===== sim/connector_equipment.sv
// Purpose: Equipment on the connector: marker source and pulse meter
// Assumes: Pin levels are sampled on the system clock
// Notes: Marker idles low between events
`default_nettype none
module connector_equipment (
  input wire logic clk_i,
  input wire logic pin_i,
  output logic marker_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial marker_o = 1'h0;
  task automatic drive(input logic v);
    @(posedge clk_i);
    marker_o <= v;
  endtask
  // Period and high time of the next full wave, period -1 on timeout
  task automatic measure(input int lim, output int per, output int hi);
    int n;
    n = 0;
    hi = 0;
    per = -1;
    while (pin_i !== 1'h0 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    while (pin_i !== 1'h1 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    n = 0;
    while (pin_i === 1'h1 && n < lim) begin
      @(negedge clk_i);
      n++;
      hi++;
    end
    while (pin_i === 1'h0 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    if (n < lim) per = n;
  endtask
endmodule
`default_nettype wire

// ===== sim/test_programmable_pin_function.sv
// Purpose: Self-checking bench for the programmable pin block
// Assumes: One second shortened to ten clock cycles
// Notes: Pulse timing is measured by the connector model
`default_nettype none
module test_programmable_pin_function;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, evp, pin0, pin1, marker;
  logic pos_valid = 1'h1;
  logic restart = 1'h0;
  logic red = 1'h0;
  logic green = 1'h0;
  logic [15:0] speed = 16'h0000;
  int fails = 0;
  int compares = 0;
  pin_function_mux #(.TICKS_PER_SEC(10)) i_dut (
    .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pos_valid_i(pos_valid), .restart_i(restart),
    .ground_speed_i(speed), .led_red_i(red), .led_green_i(green),
    .event_marker_i(marker), .event_pulse_o(evp),
    .prog_pin_zero_o(pin0), .prog_pin_one_o(pin1));
  connector_equipment i_eq (.clk_i, .pin_i(pin1), .marker_o(marker));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 20);
    if (n >= 20) begin
      fails++;
      $display("ERROR wb_ack expected 1 seen 0");
      final_report();
    end
    q = rdat;
    @(posedge clk_i);
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'h1, d, q);
  endtask
  function automatic logic [31:0] cw(input pin_mux_pkg::pin_func_t f,
                                     input logic [11:0] a);
    return {4'h0, a, 14'h0000, f};
  endfunction
  task automatic steady(input string name, input int n);
    int lows;
    lows = 0;
    repeat (n) begin
      @(negedge clk_i);
      if (pin1 !== 1'h1) lows++;
    end
    chk(name, 32'h0, 32'(lows));
  endtask
  task automatic t_reset();
    logic [31:0] q;
    bus(8'h00, 1'h0, 32'h0, q);
    chk("pin0_cfg", 32'h0, q);
    bus(8'h04, 1'h0, 32'h0, q);
    chk("pin1_cfg", 32'h0, q);
    bus(8'h08, 1'h0, 32'h0, q);
    chk("event_cfg", 32'h0, q);
    wr(8'h40, 32'hFFFFFFFF);
    bus(8'h40, 1'h0, 32'h0, q);
    chk("unmapped", 32'h0, q);
    chk("pins_idle", 32'h3, 32'({pin1, pin0}));
  endtask
  task automatic t_lost();
    int n;
    @(posedge clk_i);
    pos_valid <= 1'h0;
    wr(8'h00, cw(pin_mux_pkg::FN_POS_LOST, 12'h000));
    @(negedge clk_i);
    chk("lost_now", 32'h2, 32'({pin1, pin0}));
    @(posedge clk_i);
    pos_valid <= 1'h1;
    repeat (3) @(negedge clk_i);
    chk("resume", 32'h1, 32'(pin0));
    wr(8'h00, cw(pin_mux_pkg::FN_POS_LOST, 12'h002));
    @(posedge clk_i);
    pos_valid <= 1'h0;
    n = 0;
    while (pin0 === 1'h1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    chk("lost_delay_ok", 32'h1, 32'(n >= 21 && n <= 23));
    if (n >= 40) final_report();
    @(posedge clk_i);
    pos_valid <= 1'h1;
    repeat (3) @(posedge clk_i);
    restart <= 1'h1;
    @(posedge clk_i);
    restart <= 1'h0;
    n = 0;
    repeat (3) begin
      @(negedge clk_i);
      if (pin0 === 1'h0) n++;
    end
    chk("restart_low", 32'h1, 32'(n > 0));
    repeat (2) @(negedge clk_i);
    chk("restart_high", 32'h1, 32'(pin0));
  endtask
  task automatic t_led();
    int e;
    for (int a = 1; a <= 3; a++) begin
      wr(8'h00, cw(pin_mux_pkg::FN_LED, 12'(a)));
      for (int v = 0; v < 2; v++) begin
        @(posedge clk_i);
        red <= 1'(v);
        green <= 1'(1 - v);
        repeat (2) @(negedge clk_i);
        e = (a == 3) ? 1 : (a == 1) ? v : 1 - v;
        chk("led", 32'(e), 32'(pin0));
      end
    end
    @(posedge clk_i);
    red <= 1'h0;
    wr(8'h00, cw(pin_mux_pkg::FN_LED, 12'h001));
    @(negedge clk_i);
    chk("led_low", 32'h0, 32'(pin0));
    wr(8'h00, cw(pin_mux_pkg::FN_NONE, 12'h000));
    @(negedge clk_i);
    chk("none_high", 32'h1, 32'(pin0));
  endtask
  task automatic t_speed();
    int per, hi, p;
    bit ok;
    p = int'(1.0e8 * 256.0 / (94.0 * 22897.0));
    @(posedge clk_i);
    speed <= 16'h5971;
    wr(8'h04, cw(pin_mux_pkg::FN_SPEED_PULSE, 12'h002));
    steady("pulse_bad_arg", 6100);
    @(posedge clk_i);
    speed <= 16'h5972;
    wr(8'h04, cw(pin_mux_pkg::FN_SPEED_PULSE, 12'h001));
    steady("pulse_above_max", 6100);
    @(posedge clk_i);
    speed <= 16'h0038;
    steady("pulse_below_min", 6100);
    @(posedge clk_i);
    speed <= 16'h5971;
    i_eq.measure(40000, per, hi);
    ok = per >= p - 2 && per <= p + 2;
    chk("period_ok", 32'h1, 32'(ok));
    ok = hi * 2 >= per - 3 && hi * 2 <= per + 3;
    chk("duty_ok", 32'h1, 32'(ok));
    if (per < 0) final_report();
  endtask
  task automatic t_event(input logic [31:0] c, input int eh, el);
    int nh, nl;
    nh = 0;
    nl = 0;
    wr(8'h08, c);
    i_eq.drive(1'h1);
    repeat (4) begin
      @(negedge clk_i);
      if (evp === 1'h1) nh++;
    end
    i_eq.drive(1'h0);
    repeat (4) begin
      @(negedge clk_i);
      if (evp === 1'h1) nl++;
    end
    chk("event_rise", 32'(eh), 32'(nh));
    chk("event_fall", 32'(el), 32'(nl));
  endtask
  initial begin
    logic [31:0] q;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_lost();
    t_led();
    t_speed();
    t_event(32'h2, 1, 0);
    bus(8'h0C, 1'h0, 32'h0, q);
    chk("event_flag", 32'h1, 32'(q[4]));
    wr(8'h0C, 32'h10);
    bus(8'h0C, 1'h0, 32'h0, q);
    chk("event_clear", 32'h0, 32'(q[4]));
    t_event(32'h3, 0, 1);
    t_event(32'h0, 0, 0);
    final_report();
  end
  initial begin
    #1000000;
    fails++;
    $display("ERROR run_time expected done seen hang");
    final_report();
  end
endmodule
`default_nettype wire
